/* File: core/pvc_pkg.sv */
/*
  Constants for the vendor control register block of the PHY: register
  address, field positions, reset value, management frame figures and
  timing counts. Assumes a 20 MHz system clock.
*/
package pvc_pkg;

  localparam int          CLK_PERIOD_NS    = 50;

  localparam logic [4:0]  REG_ADDR         = 5'h10;
  localparam logic [4:0]  PHY_ADDR_DEF     = 5'h01;
  localparam logic [15:0] REG_RESET        = 16'h0140;
  localparam logic [15:0] REG_FIXED_ONES   = 16'h0140;

  localparam int          BIT_TX_TRISTATE  = 12;
  localparam int          BIT_COL_INHIBIT  = 11;
  localparam int          BIT_LOOP_10M     = 10;
  localparam int          BIT_POL_DISABLE  = 5;
  localparam int          BIT_REV_POL      = 4;
  localparam int          BIT_RSVD_HI      = 3;
  localparam int          BIT_RSVD_LO      = 2;
  localparam int          BIT_CODING_BYP   = 1;
  localparam int          BIT_RX_CLK_GATE  = 0;

  localparam int          PREAMBLE_LEN     = 32;
  localparam logic [1:0]  OP_READ          = 2'h2;
  localparam logic [1:0]  OP_WRITE         = 2'h1;
  localparam logic [1:0]  FRAME_START      = 2'h1;
  localparam int          ADDR_BITS        = 10;
  localparam int          DATA_BITS        = 16;

  localparam int          NLP_INVERT_COUNT = 8;
  localparam int          GATE_HOLD_CYC    = 64;
  localparam int          RX_DV_LEAD_SYS   = 2;
  localparam int          COL_PULSE_NS     = 1000;
  localparam int          COL_PULSE_CYC    =
    (COL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : pvc_pkg

/* File: core/pvc_sync.sv */
/*
  Three-stage synchroniser for one input from outside the clock domain.
  The filtered value moves only once the second and third stages agree.
  Assumes clk_sys and the shared active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pvc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dout <= RESET_VAL;
    end else if (ce && (s2_r == s3_r)) begin
      dout <= s3_r;
    end
  end

endmodule : pvc_sync
`default_nettype wire

/* File: core/pvc_phy_vendor_control.sv */
/*
  Vendor control register of the PHY with the behaviour it steers:
  transmitter float, collision self-test pulse, 10M natural loopback,
  receive polarity detection and correction, coding bypass and receive
  clock gating. Reached over the management serial pins (mdc, mdio).
  Assumes the MAC side signals run on clk_sys, line-side pulse and data
  indications come from the PHY analogue front end already on clk_sys,
  and mdc/mdio arrive asynchronously.
*/
// Operation
// - Tristate bit floats transmit pins and clock
// - 10M completed transmit gives collision pulse unless inhibited
// - Loopback bit returns 10M transmit nibbles to receive
// - Auto polarity correction in 10M or with autoneg, unless disable bit set
// - Reversed after 8 inverted pulses or burst
// - Detection inverts receive path, sets status bit
// - With correction off, written one forces reversal
// - Bypass passes raw 5-bit symbols both ways in 100M
// - Data valid and enable meaningless during bypass
// - Gating holds receive clock low when idle in 100M
// - Clock resumes before valid, stops 64 later
// - Basic loopback overrides receive clock gating
`timescale 1ns/1ps
`default_nettype none
module pvc_phy_vendor_control
  import pvc_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEF
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       mdc,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe,
  input  wire logic       mode_100,
  input  wire logic       aneg_enable,
  input  wire logic       basic_loopback,
  input  wire logic       tx_en,
  input  wire logic [3:0] txd,
  input  wire logic       tx_er,
  input  wire logic       line_rx_dv,
  input  wire logic [3:0] line_rxd,
  input  wire logic       line_rx_er,
  input  wire logic [4:0] line_rx_sym,
  input  wire logic       nlp_seen,
  input  wire logic       nlp_inverted,
  input  wire logic       flp_seen,
  input  wire logic       flp_inverted,
  output logic            rx_clk,
  output logic            rx_dv,
  output logic [3:0]      rxd,
  output logic            rx_er,
  output logic            col,
  output logic            tx_clk_o,
  output logic            tx_clk_oe,
  output logic            diff_tx_outputs_oe,
  output logic            line_tx_en,
  output logic [3:0]      line_txd,
  output logic [4:0]      line_tx_sym,
  output logic            line_coding_bypass,
  output logic            rx_invert
);

  typedef enum logic [5:0] {
    MS_PRE  = 6'h01,
    MS_ST   = 6'h02,
    MS_OP   = 6'h04,
    MS_ADDR = 6'h08,
    MS_TA   = 6'h10,
    MS_DATA = 6'h20
  } pvc_mstate_t;

  // Register fields
  logic        tx_tristate_r;
  logic        collision_selftest_inhibit_r;
  logic        natural_loopback_10m_r;
  logic        polarity_correct_disable_r;
  logic        reversed_polarity_r;
  logic [1:0]  rsvd_rw_r;
  logic        coding_bypass_r;
  logic        rx_clock_gating_r;
  logic [15:0] reg_rd;

  // Management frame
  logic        mdc_s;
  logic        mdio_s;
  logic        mdc_d_r;
  logic        mdc_rise;
  pvc_mstate_t ms_r;
  logic [5:0]  ms_cnt_r;
  logic        ms_first_r;
  logic        ms_read_r;
  logic [9:0]  ms_addr_r;
  logic [15:0] ms_shift_r;
  logic        ms_hit;
  logic        wr_stb;
  logic [15:0] wr_data;

  pvc_sync #(.RESET_VAL(1'b0)) u_sync_mdc (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .ce      (ce),
    .din     (mdc),
    .dout    (mdc_s)
  );

  pvc_sync #(.RESET_VAL(1'b1)) u_sync_mdio (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .ce      (ce),
    .din     (mdio_i),
    .dout    (mdio_s)
  );

  assign mdc_rise = mdc_s && !mdc_d_r;
  assign ms_hit   = (ms_addr_r[9:5] == PHY_ADDR) && (ms_addr_r[4:0] == REG_ADDR);
  assign wr_stb   = ce && mdc_rise && (ms_r == MS_DATA) && !ms_read_r && ms_hit
                    && (ms_cnt_r == 6'(DATA_BITS - 1));
  assign wr_data  = {ms_shift_r[14:0], mdio_s};

  // Fixed positions come straight from constants
  assign reg_rd = REG_FIXED_ONES
                | (16'(tx_tristate_r)                << BIT_TX_TRISTATE)
                | (16'(collision_selftest_inhibit_r) << BIT_COL_INHIBIT)
                | (16'(natural_loopback_10m_r)       << BIT_LOOP_10M)
                | (16'(polarity_correct_disable_r)   << BIT_POL_DISABLE)
                | (16'(reversed_polarity_r)          << BIT_REV_POL)
                | (16'(rsvd_rw_r)                    << BIT_RSVD_LO)
                | (16'(coding_bypass_r)              << BIT_CODING_BYP)
                | (16'(rx_clock_gating_r)            << BIT_RX_CLK_GATE);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mdc_d_r <= 1'b0;
    end else if (ce) begin
      mdc_d_r <= mdc_s;
    end
  end

  // Frame sequencer, sampled on each rising mdc edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ms_r       <= MS_PRE;
      ms_cnt_r   <= 6'h00;
      ms_first_r <= 1'b0;
      ms_read_r  <= 1'b0;
      ms_addr_r  <= 10'h000;
      ms_shift_r <= 16'h0000;
      mdio_o     <= 1'b0;
      mdio_oe    <= 1'b0;
    end else if (ce && mdc_rise) begin
      case (ms_r)
        MS_PRE: begin
          mdio_oe <= 1'b0;
          if (!mdio_s) begin
            ms_cnt_r <= 6'h00;
            if (ms_cnt_r == 6'(PREAMBLE_LEN)) begin
              ms_r <= MS_ST;
            end
          end else if (ms_cnt_r != 6'(PREAMBLE_LEN)) begin
            ms_cnt_r <= ms_cnt_r + 6'h01;
          end
        end
        MS_ST: begin
          ms_r     <= (mdio_s == FRAME_START[0]) ? MS_OP : MS_PRE;
          ms_cnt_r <= 6'h00;
        end
        MS_OP: begin
          if (ms_cnt_r == 6'h00) begin
            ms_first_r <= mdio_s;
            ms_cnt_r   <= 6'h01;
          end else if ({ms_first_r, mdio_s} == OP_READ ||
                       {ms_first_r, mdio_s} == OP_WRITE) begin
            ms_read_r <= ({ms_first_r, mdio_s} == OP_READ);
            ms_r      <= MS_ADDR;
            ms_cnt_r  <= 6'h00;
          end else begin
            ms_r     <= MS_PRE;
            ms_cnt_r <= 6'h00;
          end
        end
        MS_ADDR: begin
          ms_addr_r <= {ms_addr_r[8:0], mdio_s};
          ms_cnt_r  <= ms_cnt_r + 6'h01;
          if (ms_cnt_r == 6'(ADDR_BITS - 1)) begin
            ms_r     <= MS_TA;
            ms_cnt_r <= 6'h00;
          end
        end
        MS_TA: begin
          ms_cnt_r <= ms_cnt_r + 6'h01;
          if (ms_cnt_r == 6'h00) begin
            ms_shift_r <= reg_rd;
            if (ms_read_r && ms_hit) begin
              mdio_oe <= 1'b1;
              mdio_o  <= 1'b0;
            end
          end else begin
            ms_r     <= MS_DATA;
            ms_cnt_r <= 6'h00;
            if (ms_read_r && ms_hit) begin
              mdio_o     <= ms_shift_r[15];
              ms_shift_r <= {ms_shift_r[14:0], 1'b0};
            end
          end
        end
        MS_DATA: begin
          ms_cnt_r <= ms_cnt_r + 6'h01;
          if (ms_read_r) begin
            mdio_o     <= ms_shift_r[15];
            ms_shift_r <= {ms_shift_r[14:0], 1'b0};
          end else begin
            ms_shift_r <= wr_data;
          end
          if (ms_cnt_r == 6'(DATA_BITS - 1)) begin
            ms_r     <= MS_PRE;
            ms_cnt_r <= 6'h00;
            mdio_oe  <= 1'b0;
          end
        end
        default: begin
          ms_r     <= MS_PRE;
          ms_cnt_r <= 6'h00;
          mdio_oe  <= 1'b0;
        end
      endcase
    end
  end

  // Writable fields; read-only positions never stored
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_tristate_r                <= REG_RESET[BIT_TX_TRISTATE];
      collision_selftest_inhibit_r <= REG_RESET[BIT_COL_INHIBIT];
      natural_loopback_10m_r       <= REG_RESET[BIT_LOOP_10M];
      polarity_correct_disable_r   <= REG_RESET[BIT_POL_DISABLE];
      rsvd_rw_r                    <= REG_RESET[BIT_RSVD_HI:BIT_RSVD_LO];
      coding_bypass_r              <= REG_RESET[BIT_CODING_BYP];
      rx_clock_gating_r            <= REG_RESET[BIT_RX_CLK_GATE];
    end else if (wr_stb) begin
      tx_tristate_r                <= wr_data[BIT_TX_TRISTATE];
      collision_selftest_inhibit_r <= wr_data[BIT_COL_INHIBIT];
      natural_loopback_10m_r       <= wr_data[BIT_LOOP_10M];
      polarity_correct_disable_r   <= wr_data[BIT_POL_DISABLE];
      rsvd_rw_r                    <= wr_data[BIT_RSVD_HI:BIT_RSVD_LO];
      coding_bypass_r              <= wr_data[BIT_CODING_BYP];
      rx_clock_gating_r            <= wr_data[BIT_RX_CLK_GATE];
    end
  end

  // Polarity detection and status
  logic       pol_auto;
  logic [3:0] nlp_inv_cnt_r;

  assign pol_auto = !polarity_correct_disable_r && (aneg_enable || !mode_100);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nlp_inv_cnt_r       <= 4'h0;
      reversed_polarity_r <= REG_RESET[BIT_REV_POL];
    end else if (ce) begin
      if (nlp_seen) begin
        nlp_inv_cnt_r <= !nlp_inverted ? 4'h0 :
                         (nlp_inv_cnt_r == 4'(NLP_INVERT_COUNT)) ? nlp_inv_cnt_r :
                         nlp_inv_cnt_r + 4'h1;
      end
      if (pol_auto && ((nlp_seen && nlp_inverted &&
                        nlp_inv_cnt_r == 4'(NLP_INVERT_COUNT - 1)) ||
                       (flp_seen && flp_inverted))) begin
        reversed_polarity_r <= 1'b1;
      end else if (wr_stb && polarity_correct_disable_r) begin
        reversed_polarity_r <= wr_data[BIT_REV_POL];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_invert <= 1'b0;
    end else if (ce) begin
      rx_invert <= reversed_polarity_r &&
                   (pol_auto || polarity_correct_disable_r);
    end
  end

  // Transmit side
  logic             tx_en_d_r;
  logic [5:0]       col_cnt_r;
  logic             bypass_on;

  assign bypass_on = coding_bypass_r && mode_100;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_clk_o           <= 1'b0;
      tx_clk_oe          <= 1'b0;
      diff_tx_outputs_oe <= 1'b0;
      line_tx_en         <= 1'b0;
      line_txd           <= 4'h0;
      line_tx_sym        <= 5'h00;
      line_coding_bypass <= 1'b0;
    end else if (ce) begin
      tx_clk_o           <= !tx_clk_o;
      tx_clk_oe          <= !tx_tristate_r;
      diff_tx_outputs_oe <= !tx_tristate_r;
      line_coding_bypass <= bypass_on;
      line_tx_sym        <= {tx_er, txd};
      line_tx_en         <= bypass_on ? 1'b0 : tx_en;
      line_txd           <= txd;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_en_d_r <= 1'b0;
      col_cnt_r <= 6'h00;
      col       <= 1'b0;
    end else if (ce) begin
      tx_en_d_r <= tx_en;
      if (tx_en_d_r && !tx_en && !mode_100 && !collision_selftest_inhibit_r) begin
        col_cnt_r <= 6'(COL_PULSE_CYC);
      end else if (col_cnt_r != 6'h00) begin
        col_cnt_r <= col_cnt_r - 6'h01;
      end
      col <= (col_cnt_r != 6'h00);
    end
  end

  // Receive side: data is delayed so the clock leads valid
  logic       loop_on;
  logic       src_dv;
  logic [4:0] src_dat;
  logic [1:0] dv_pipe_r;
  logic [9:0] dat_pipe_r;

  assign loop_on = natural_loopback_10m_r && !mode_100;
  assign src_dv  = loop_on ? tx_en : (bypass_on ? 1'b0 : line_rx_dv);
  assign src_dat = loop_on ? {1'b0, txd} :
                   bypass_on ? line_rx_sym :
                   {line_rx_er, line_rxd};

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dv_pipe_r  <= 2'h0;
      dat_pipe_r <= 10'h000;
      rx_dv      <= 1'b0;
      rxd        <= 4'h0;
      rx_er      <= 1'b0;
    end else if (ce) begin
      dv_pipe_r  <= {dv_pipe_r[0], src_dv};
      dat_pipe_r <= {dat_pipe_r[4:0], src_dat};
      rx_dv      <= dv_pipe_r[RX_DV_LEAD_SYS - 1];
      {rx_er, rxd} <= dat_pipe_r[9:5];
    end
  end

  // Receive clock gating
  logic       gate_on;
  logic       rx_clk_run;
  logic [6:0] gate_hold_r;

  assign gate_on    = rx_clock_gating_r && mode_100 && !basic_loopback;
  assign rx_clk_run = !gate_on || src_dv || (dv_pipe_r != 2'h0) || rx_dv ||
                      (gate_hold_r != 7'h00);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gate_hold_r <= 7'h00;
      rx_clk      <= 1'b0;
    end else if (ce) begin
      if (rx_dv) begin
        gate_hold_r <= 7'(GATE_HOLD_CYC);
      end else if (gate_hold_r != 7'h00 && rx_clk) begin
        gate_hold_r <= gate_hold_r - 7'h01;
      end
      rx_clk <= rx_clk_run ? !rx_clk : 1'b0;
    end
  end

endmodule : pvc_phy_vendor_control
`default_nettype wire

/* File: sim/pvc_vc_sva.sv */
/*
  Port assertions for the vendor control block, bound to every instance.
  Assumes one clk_sys domain with rstn as its asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pvc_vc_sva
  import pvc_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       mode_100,
  input wire logic       basic_loopback,
  input wire logic       tx_en,
  input wire logic [3:0] txd,
  input wire logic       tx_er,
  input wire logic [4:0] line_rx_sym,
  input wire logic       rx_clk,
  input wire logic       rx_dv,
  input wire logic [3:0] rxd,
  input wire logic       rx_er,
  input wire logic       col,
  input wire logic       tx_clk_oe,
  input wire logic       tx_clk_o,
  input wire logic       diff_tx_outputs_oe,
  input wire logic       line_tx_en,
  input wire logic [3:0] line_txd,
  input wire logic [4:0] line_tx_sym,
  input wire logic       line_coding_bypass
);
  localparam int COLN = COL_PULSE_CYC;
  int col_len_r;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Length of the current collision pulse
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) col_len_r <= 0;
    else col_len_r <= col ? col_len_r + 1 : 0;
  end

  AST_TX_FLOAT: assert property (diff_tx_outputs_oe == tx_clk_oe)
    else $error("transmit pin and clock enables differ");
  AST_COL_LEN: assert property ($fell(col) |-> col_len_r == COLN)
    else $error("collision pulse length wrong");
  AST_COL_START: assert property ($rose(col) |-> $past(tx_en, 3) && !$past(tx_en, 2))
    else $error("collision pulse not two cycles after transmit end");
  AST_COL_10M: assert property ($rose(col) |-> !mode_100)
    else $error("collision pulse outside 10M");
  AST_BYP_NO_EN: assert property (line_coding_bypass |-> !line_tx_en)
    else $error("transmit enable passed in bypass");
  AST_BYP_TX: assert property (line_coding_bypass |-> line_tx_sym == $past({tx_er, txd}))
    else $error("bypass transmit symbol wrong");
  AST_BYP_RX: assert property (
    line_coding_bypass && $past(line_coding_bypass, 4)
    |-> {rx_er, rxd} == $past(line_rx_sym, 3) && !rx_dv)
    else $error("bypass receive symbol wrong");
  AST_TX_NIB: assert property (
    !line_coding_bypass |-> line_txd == $past(txd) && line_tx_en == $past(tx_en))
    else $error("transmit nibble not passed through");
  AST_TX_CLK: assert property ($past(rstn) |-> $changed(tx_clk_o))
    else $error("transmit clock not toggling");
  AST_CLK_LEAD: assert property ($rose(rx_dv) |-> $past(rx_clk, 2) != $past(rx_clk))
    else $error("receive clock not running before data valid");
  AST_CLK_TAIL: assert property ($fell(rx_dv) |-> ($changed(rx_clk)) [*8])
    else $error("receive clock stopped right after data valid");
  AST_LOOP_RUN: assert property (
    basic_loopback && $past(basic_loopback, 3) |-> $changed(rx_clk))
    else $error("receive clock gated under basic loopback");
endmodule : pvc_vc_sva

bind pvc_phy_vendor_control pvc_vc_sva u_sva (
  .clk_sys, .rstn, .mode_100, .basic_loopback, .tx_en, .txd, .tx_er, .line_rx_sym,
  .rx_clk, .rx_dv, .rxd, .rx_er, .col, .tx_clk_oe, .tx_clk_o, .diff_tx_outputs_oe,
  .line_tx_en, .line_txd, .line_tx_sym, .line_coding_bypass
);
`default_nettype wire

/* File: sim/pvc_mac_model.sv */
/*
  MAC side of the nibble interface: sends one frame of 8 nibbles per go.
  Assumes go is a one-cycle pulse on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module pvc_mac_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       go,
  input  wire logic       sym_mode,
  output logic            tx_en,
  output logic [3:0]      txd,
  output logic            tx_er
);
  logic [3:0] cnt_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 4'h0;
      tx_en <= 1'b0;
      txd   <= 4'h0;
      tx_er <= 1'b0;
    end else if (go || cnt_r != 4'h0) begin
      cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
      tx_en <= ~sym_mode & (cnt_r != 4'h8);
      txd   <= cnt_r + 4'h1;
      tx_er <= sym_mode & cnt_r[0];
    end else begin
      // Idle nibbles are not held
      tx_en <= 1'b0;
      txd   <= ~txd;
      tx_er <= 1'b0;
    end
  end
endmodule : pvc_mac_model
`default_nettype wire

/* File: sim/test_phy_vendor_control_reg.sv */
/*
  Self-checking bench for the vendor control block with a MAC model.
  Assumes management frames on mdc at 400 ns and a pulled-up mdio line.
*/
`timescale 1ns/1ps
`default_nettype none
module test_phy_vendor_control_reg
  import pvc_pkg::*;
;
  logic clk_sys, rstn, mdc, md_drv, md_en, mode_100, aneg_enable, basic_loopback;
  logic line_rx_dv, nlp_seen, nlp_inverted, flp_seen, flp_inverted, go, sym_mode;
  logic mdio_o, mdio_oe, tx_en, tx_er, rx_clk, rx_dv, rx_er, col, tx_clk_oe;
  logic diff_tx_outputs_oe, line_tx_en, line_coding_bypass, rx_invert;
  logic [3:0] txd, rxd, line_txd, line_rxd;
  logic [4:0] line_tx_sym, line_rx_sym;
  logic [3:0] q[$];
  wire logic  mdio_line;
  int         n_fail, compares, c;

  assign mdio_line = mdio_oe ? mdio_o : (md_en ? md_drv : 1'b1);

  pvc_phy_vendor_control DUT (.clk_sys, .rstn, .ce(1'b1), .mdc, .mdio_i(mdio_line), .mdio_o,
    .mdio_oe, .mode_100, .aneg_enable, .basic_loopback, .tx_en, .txd, .tx_er, .line_rx_dv,
    .line_rxd, .line_rx_er(1'b0), .line_rx_sym, .nlp_seen, .nlp_inverted, .flp_seen,
    .flp_inverted, .rx_clk, .rx_dv, .rxd, .rx_er, .col, .tx_clk_o(), .tx_clk_oe,
    .diff_tx_outputs_oe, .line_tx_en, .line_txd, .line_tx_sym, .line_coding_bypass, .rx_invert);
  pvc_mac_model u_mac (.clk_sys, .rstn, .go, .sym_mode, .tx_en, .txd, .tx_er);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic mbit(input logic b, output logic s);
    md_drv <= b;
    repeat (4) @(posedge clk_sys);
    s = mdio_line;
    mdc <= 1'b1;
    repeat (4) @(posedge clk_sys);
    mdc <= 1'b0;
  endtask : mbit

  task automatic mframe(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] h;
    logic        s;
    h = {FRAME_START, op, pa, ra};
    @(posedge clk_sys);
    md_en <= 1'b1;
    repeat (PREAMBLE_LEN) mbit(1'b1, s);
    for (int i = 13; i >= 0; i--) mbit(h[i], s);
    md_en <= (op == OP_WRITE);
    mbit(1'b1, s);
    mbit(1'b0, s);
    for (int i = DATA_BITS - 1; i >= 0; i--) mbit(wd[i], rd[i]);
    md_en <= 1'b0;
    repeat (12) @(posedge clk_sys);
  endtask : mframe

  task automatic wr(input logic [15:0] d);
    logic [15:0] r;
    mframe(OP_WRITE, PHY_ADDR_DEF, REG_ADDR, d, r);
  endtask : wr

  task automatic rdc(input string nm, input logic [15:0] e);
    logic [15:0] r;
    mframe(OP_READ, PHY_ADDR_DEF, REG_ADDR, 16'hffff, r);
    chk(nm, e, r);
  endtask : rdc

  task automatic rst();
    rstn <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask : rst

  task automatic send(input logic sm);
    q.delete();
    c = 0;
    sym_mode <= sm;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (60) begin
      @(posedge clk_sys);
      #1;
      if (col === 1'b1) c++;
      if (rx_dv === 1'b1) q.push_back(rxd);
    end
  endtask : send

  task automatic ncnt(input int n);
    logic p;
    @(posedge clk_sys);
    #1 p = rx_clk;
    c = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      if (rx_clk !== p) c++;
      p = rx_clk;
    end
  endtask : ncnt

  task automatic pulses(input logic f, input logic inv, input int n);
    repeat (n) begin
      nlp_seen <= ~f;
      flp_seen <= f;
      nlp_inverted <= inv;
      flp_inverted <= inv;
      @(posedge clk_sys);
      nlp_seen <= 1'b0;
      flp_seen <= 1'b0;
      @(posedge clk_sys);
    end
    repeat (3) @(posedge clk_sys);
  endtask : pulses

  task automatic t_regs();
    logic [15:0] r;
    rdc("reset value", REG_RESET);
    wr(16'he3c0);
    rdc("read-only bits", REG_RESET);
    mframe(OP_WRITE, PHY_ADDR_DEF + 5'h1, REG_ADDR, 16'h1000, r);
    rdc("other phy write", REG_RESET);
    mframe(OP_READ, PHY_ADDR_DEF, REG_ADDR + 5'h1, 16'h0000, r);
    chk("unmapped read", 16'hffff, r);
    wr(16'h1000);
    chk("tx enables off", 16'h0, 16'({diff_tx_outputs_oe, tx_clk_oe}));
    rdc("tristate bit", 16'h1140);
    wr(16'h0000);
    chk("tx enables on", 16'h3, 16'({diff_tx_outputs_oe, tx_clk_oe}));
    $display("test registers done");
  endtask : t_regs

  task automatic t_col_loop();
    send(1'b0);
    chk("col cycles", 16'(COL_PULSE_CYC), 16'(c));
    chk("no loopback", 16'h0, 16'(q.size()));
    wr(16'h0800);
    send(1'b0);
    chk("col inhibited", 16'h0, 16'(c));
    wr(16'h0400);
    send(1'b0);
    chk("loop count", 16'h8, 16'(q.size()));
    for (int i = 0; i < 8; i++) chk("loop nibble", 16'(i + 1), 16'(q[i]));
    $display("test collision and loopback done");
  endtask : t_col_loop

  task automatic t_pol();
    rst();
    pulses(1'b0, 1'b1, 7);
    pulses(1'b0, 1'b0, 1);
    pulses(1'b0, 1'b1, 7);
    chk("pol after 7", 16'h0, 16'(rx_invert));
    pulses(1'b0, 1'b1, 1);
    chk("pol after 8", 16'h1, 16'(rx_invert));
    rdc("pol status", 16'h0150);
    rst();
    mode_100 <= 1'b1;
    aneg_enable <= 1'b1;
    pulses(1'b1, 1'b0, 1);
    chk("burst normal", 16'h0, 16'(rx_invert));
    pulses(1'b1, 1'b1, 1);
    chk("burst inverted", 16'h1, 16'(rx_invert));
    rst();
    mode_100 <= 1'b0;
    aneg_enable <= 1'b0;
    wr(16'h0020);
    pulses(1'b1, 1'b1, 1);
    chk("auto disabled", 16'h0, 16'(rx_invert));
    wr(16'h0030);
    chk("forced reversal", 16'h1, 16'(rx_invert));
    rdc("forced status", 16'h0170);
    $display("test polarity done");
  endtask : t_pol

  task automatic t_byp();
    rst();
    mode_100 <= 1'b1;
    wr(16'h0002);
    line_rx_sym <= 5'h15;
    send(1'b1);
    chk("bypass rx symbol", 16'h15, 16'({rx_er, rxd}));
    chk("bypass rx valid", 16'h0, 16'(rx_dv));
    chk("bypass flag", 16'h1, 16'(line_coding_bypass));
    $display("test bypass done");
  endtask : t_byp

  task automatic t_gate();
    wr(16'h0001);
    repeat (200) @(posedge clk_sys);
    ncnt(20);
    chk("gated idle", 16'h0, 16'(c));
    basic_loopback <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ncnt(20);
    chk("loopback clock", 16'd20, 16'(c));
    basic_loopback <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ncnt(4);
    chk("gated again", 16'h0, 16'(c));
    line_rxd <= 4'h5;
    line_rx_dv <= 1'b1;
    repeat (16) @(posedge clk_sys);
    line_rx_dv <= 1'b0;
    repeat (100) @(posedge clk_sys);
    ncnt(10);
    chk("clock tail", 16'd10, 16'(c));
    repeat (40) @(posedge clk_sys);
    ncnt(10);
    chk("clock stopped", 16'h0, 16'(c));
    $display("test clock gating done");
  endtask : t_gate

  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    {rstn, mdc, md_en, mode_100, aneg_enable, basic_loopback, line_rx_dv} = 7'h0;
    {nlp_seen, nlp_inverted, flp_seen, flp_inverted, go, sym_mode} = 6'h0;
    md_drv = 1'b1;
    line_rxd = 4'h0;
    line_rx_sym = 5'h0;
    n_fail = 0;
    compares = 0;
    rst();
    t_regs();
    t_col_loop();
    t_pol();
    t_byp();
    t_gate();
    test_done();
  end

  initial begin
    #3_000_000;
    n_fail++;
    $display("watchdog expired");
    test_done();
  end
endmodule : test_phy_vendor_control_reg
`default_nettype wire
